// file: logic/adcb_byte_out.sv
// result byte output: direct and handshake transfer, apb, interrupt
//
// The APB interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "adcb_consts.svh"
module adcb_byte_out
  import adcb_pkg::*;
#(
  parameter int RES_BITS    = 16,
  parameter int CONV_COUNTS = `ADCB_CONV_16,
  parameter int TICK_DIV    = `ADCB_TICK_DIV
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  input  wire logic        mode,
  input  wire logic        run_hold_select,
  input  wire logic        transmit_permit,
  input  wire logic        comparator_in,
  output logic             conversion_status,
  output logic [15:0]      data_out,
  output logic [15:0]      data_oe,
  output logic             sign_out,
  output logic             sign_oe,
  output logic             overrange_out,
  output logic             overrange_oe,
  input  wire logic        low_byte_enable_in,
  output logic             low_byte_enable_out,
  output logic             low_byte_enable_oe,
  input  wire logic        mid_byte_enable_in,
  output logic             mid_byte_enable_out,
  output logic             mid_byte_enable_oe,
  input  wire logic        high_byte_enable_in,
  output logic             high_byte_enable_out,
  output logic             high_byte_enable_oe,
  input  wire logic        chip_enable_load_in,
  output logic             chip_enable_load_out,
  output logic             chip_enable_load_oe
);
  localparam bit RES14 = (RES_BITS == 14);
  localparam logic [1:0] LAST_IDX = RES14 ? 2'h1 : 2'h2;
  localparam logic [7:0] DIV_END = 8'(TICK_DIV - 1);

  adcb_top_st_t q;
  adcb_top_st_t n;
  adcb_result_t seq_res;
  logic         seq_status;
  logic         seq_done;

  // converter timing and result counting
  adcb_phase_seq #(
    .CONV_COUNTS (CONV_COUNTS)
  ) u_seq (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (q.tick),
    .run     (q.s2[`ADCB_SY_RUN]),
    .start   (q.start),
    .comp    (q.s2[`ADCB_SY_COMP]),
    .result  (seq_res),
    .status  (seq_status),
    .done    (seq_done)
  );

  logic       m_hs;
  logic       permit;
  logic       cel;
  logic       hs_go;
  logic [1:0] grp;
  logic [2:0] grp_en;
  logic [2:0] evt;
  logic [2:0] clr;

  always_comb
  begin
    n = q;
    n.start = 1'b0;
    evt = '0;
    clr = '0;
    // pins cross in through two flops each
    n.s1 = {chip_enable_load_in, high_byte_enable_in,
            mid_byte_enable_in, low_byte_enable_in, comparator_in,
            transmit_permit, run_hold_select, mode};
    n.s2 = q.s1;
    // pins stay outputs until a pulse-started transfer has finished
    m_hs = q.s2[`ADCB_SY_MODE] || (q.hs != ADCB_HS_IDLE);
    permit = q.s2[`ADCB_SY_PERMIT];
    cel = q.s2[`ADCB_SY_CEL];
    n.mode_prev = q.s2[`ADCB_SY_MODE];

    // converter count enable
    n.tick = (q.div == DIV_END);
    n.div = n.tick ? 8'h00 : q.div + 8'h01;

    // result stays latched until the next conversion completes
    if (seq_done)
    begin
      n.res = seq_res;
      evt[`ADCB_EVT_DONE] = 1'b1;
      evt[`ADCB_EVT_OVR] = seq_res.ovr;
    end

    // handshake entry at completion, or at once on a mode pulse
    hs_go = q.s2[`ADCB_SY_MODE] && (seq_done || !q.mode_prev);
    unique case (q.hs)
      ADCB_HS_IDLE:
        if (hs_go)
        begin
          n.hs = ADCB_HS_WAIT;
          n.idx = 2'h0;
        end
      ADCB_HS_WAIT:
        if (permit && q.tick)
          n.hs = ADCB_HS_SEND;
      ADCB_HS_SEND:
        if (q.tick)
          n.hs = ADCB_HS_GAP;
      ADCB_HS_GAP:
        if (q.tick)
        begin
          if (q.idx == LAST_IDX)
          begin
            n.hs = ADCB_HS_IDLE;
            evt[`ADCB_EVT_HSDONE] = 1'b1;
          end
          else
          begin
            n.idx = q.idx + 2'h1;
            n.hs = ADCB_HS_WAIT;
          end
        end
    endcase
    // on the short variant the second byte is the high group
    grp = (RES14 && q.idx == 2'h1) ? 2'h2 : q.idx;
    if (m_hs)
      grp_en = (q.hs == ADCB_HS_SEND) ? 3'(3'h1 << grp) : 3'h0;
    else
      // enables are active low, load pin is a master disable
      grp_en = {~q.s2[`ADCB_SY_BEN_HI], ~q.s2[`ADCB_SY_BEN_MID],
                ~q.s2[`ADCB_SY_BEN_LO]} & {3{~cel}};
    if (RES14)
      grp_en[1] = 1'b0;

    // per-bit drive: active-high data, undriven unless enabled
    n.data = q.res.mag;
    for (int i = 0; i < 16; i++)
    begin
      if (i < 8)
        n.data_oe[i] = grp_en[0];
      else if (i >= RES_BITS)
        n.data_oe[i] = 1'b0;
      else if (RES14)
        n.data_oe[i] = grp_en[2];
      else
        n.data_oe[i] = grp_en[1];
    end
    n.sign_oe = grp_en[2];
    n.ovr_oe = grp_en[2];

    // handshake turns the load pin and the enables into outputs, except the mid enable on the 14-bit variant
    n.ben_oe = m_hs ? (RES14 ? 3'h5 : 3'h7) : 3'h0;
    n.ben_out = ~grp_en | {3{~m_hs}};
    n.cel_oe = m_hs;
    n.cel_out = !(m_hs && q.hs == ADCB_HS_SEND);

    // apb: one wait state so read data leaves a flop
    if (psel && penable && !q.pready)
    begin
      n.pready = 1'b1;
      n.pslverr = 1'b0;
      n.prdata = '0;
      unique case (paddr)
        `ADCB_OFF_CTRL, `ADCB_OFF_IRQ_CLR:
          n.prdata = 32'h0;                         // write-only
        `ADCB_OFF_RESULT:
          n.prdata = {13'h0000, seq_status, q.res.ovr, q.res.sign,
                      q.res.mag};
        `ADCB_OFF_IRQ_ST:
          n.prdata = {29'h0, q.irq_st};
        `ADCB_OFF_IRQ_EN:
          n.prdata = {29'h0, q.irq_en};
        default:
          n.pslverr = 1'b1;
      endcase
    end
    else if (psel && penable && q.pready)
    begin
      n.pready = 1'b0;
      n.pslverr = 1'b0;
      if (pwrite && !q.pslverr)
      begin
        unique case (paddr)
          `ADCB_OFF_CTRL:
            n.start = pwdata[`ADCB_CTRL_START];
          `ADCB_OFF_IRQ_CLR:
            clr = pwdata[2:0];
          `ADCB_OFF_IRQ_EN:
            n.irq_en = pwdata[2:0];
          default:
            n.start = 1'b0;
        endcase
      end
    end

    // sticky events: a new event beats a clear in the same cycle
    n.irq_st = (q.irq_st & ~clr) | evt;
    n.irq = |(n.irq_st & n.irq_en);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      q <= '0;
      // enable and load pins idle high: no false enable after reset
      q.s1 <= `ADCB_SYNC_RST;
      q.s2 <= `ADCB_SYNC_RST;
      q.ben_out <= 3'h7;
      q.cel_out <= 1'b1;
      q.irq_en <= `ADCB_IRQ_EN_RST;
    end
    else
      q <= n;
  end

  // pins and bus answers straight from flops
  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign irq = q.irq;
  assign conversion_status = seq_status;
  assign data_out = q.data;
  assign data_oe = q.data_oe;
  assign sign_out = q.res.sign;
  assign sign_oe = q.sign_oe;
  assign overrange_out = q.res.ovr;
  assign overrange_oe = q.ovr_oe;
  assign low_byte_enable_out = q.ben_out[0];
  assign low_byte_enable_oe = q.ben_oe[0];
  assign mid_byte_enable_out = q.ben_out[1];
  assign mid_byte_enable_oe = q.ben_oe[1];
  assign high_byte_enable_out = q.ben_out[2];
  assign high_byte_enable_oe = q.ben_oe[2];
  assign chip_enable_load_out = q.cel_out;
  assign chip_enable_load_oe = q.cel_oe;

  // refuse widths and rates that the logic cannot serve
  if (RES_BITS != 16 && RES_BITS != 14)
  begin : g_bad_res
    $error("adcb_byte_out: RES_BITS must be 14 or 16");
  end
  if (TICK_DIV < 1 || TICK_DIV > 256)
  begin : g_bad_div
    $error("adcb_byte_out: TICK_DIV out of range");
  end
  if (CONV_COUNTS > (2 << RES_BITS))
  begin : g_bad_span
    $error("adcb_byte_out: full scale wider than the result");
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_result_latch:
    assert property (seq_done |=> q.res == $past(seq_res))
    else $error("result not latched at completion");
  chk_idle_hiz:
    assert property ((m_hs && q.hs != ADCB_HS_SEND)
      |=> (q.data_oe == 16'h0000 && !q.sign_oe))
    else $error("output driven with no group enabled");
  chk_master_off:
    assert property ((!m_hs && cel)
      |=> (q.data_oe == 16'h0000 && !q.ovr_oe))
    else $error("load pin high did not disable outputs");
  chk_low_byte_on:
    assert property ((!m_hs && !cel && !q.s2[`ADCB_SY_BEN_LO])
      |=> q.data_oe[7:0] == 8'hFF)
    else $error("low byte not driven");
  chk_high_grp_on:
    assert property ((!m_hs && !cel && !q.s2[`ADCB_SY_BEN_HI])
      |=> (q.sign_oe && q.ovr_oe))
    else $error("sign and overrange not driven");
  chk_flag_low:
    assert property ((m_hs && q.hs == ADCB_HS_SEND && q.idx == 2'h0)
      |=> (!q.ben_out[0] && q.ben_oe[0] && !q.cel_out))
    else $error("low byte flag or load strobe missing");
  chk_permit_wait:
    assert property ((q.hs == ADCB_HS_WAIT && !permit)
      |=> q.hs != ADCB_HS_SEND)
    else $error("byte sent without permit");
  chk_hs_entry:
    assert property ((m_hs && seq_done && q.hs == ADCB_HS_IDLE)
      |=> q.hs == ADCB_HS_WAIT)
    else $error("handshake not entered at completion");
  chk_irq_sticky:
    assert property (seq_done |=> q.irq_st[`ADCB_EVT_DONE])
    else $error("completion event lost");

  cov_conversion: cover property (seq_done);
  cov_handshake: cover property (evt[`ADCB_EVT_HSDONE]);
  cov_direct_read:
    cover property (!m_hs && !cel && !q.s2[`ADCB_SY_BEN_LO]);
  cov_overrange: cover property (seq_done && seq_res.ovr);
endmodule : adcb_byte_out
`default_nettype wire

// file: logic/adcb_phase_seq.sv
// conversion phase sequencer: auto-zero, integrate, deintegrate
`timescale 1ns/1ps
`default_nettype none
`include "adcb_consts.svh"
module adcb_phase_seq
  import adcb_pkg::*;
#(
  parameter int CONV_COUNTS = `ADCB_CONV_16
) (
  input  wire logic   pclk,
  input  wire logic   presetn,
  input  wire logic   tick,
  input  wire logic   run,
  input  wire logic   start,
  input  wire logic   comp,
  output adcb_result_t result,
  output logic         status,
  output logic         done
);
  localparam int CW = `ADCB_CNT_W;
  localparam logic [CW-1:0] LAST = CW'(CONV_COUNTS - 1);
  localparam logic [CW-1:0] INT_END = CW'(CONV_COUNTS / 4 - 1);
  localparam logic [CW-1:0] FS_END = CW'(CONV_COUNTS / 2 - 1);
  localparam logic [CW-1:0] HALT = CW'(CONV_COUNTS - `ADCB_HALT_LEAD);

  adcb_seq_st_t q;
  adcb_seq_st_t n;

  // one step of the sequence per converter count
  always_comb
  begin
    n = q;
    n.done = 1'b0;
    if (start)
      n.go = 1'b1;
    if (tick)
    begin
      unique case (q.phase)
        ADCB_PH_AZ:
          if (q.cnt == HALT && !run && !q.go)
            n.cnt = q.cnt;
          else if (q.cnt == LAST)
          begin
            n.phase = ADCB_PH_INT;
            n.cnt = '0;
            n.go = 1'b0;
          end
          else
            n.cnt = q.cnt + 1'b1;
        ADCB_PH_INT:
        begin
          n.cnt = q.cnt + 1'b1;
          if (q.cnt == INT_END)
          begin
            n.phase = ADCB_PH_DE;
            n.dcnt = '0;
            n.res.sign = comp;
          end
        end
        ADCB_PH_DE:
        begin
          n.cnt = q.cnt + 1'b1;
          n.dcnt = q.dcnt + 1'b1;
          // crossing or full scale ends deintegration and latches
          if (comp != q.res.sign || q.dcnt == FS_END)
          begin
            n.phase = ADCB_PH_AZ;
            n.res.mag = q.dcnt[15:0];
            n.res.ovr = (comp == q.res.sign);
            n.done = 1'b1;
          end
        end
        // the unused code falls back to auto-zero
        default:
          n.phase = ADCB_PH_AZ;
      endcase
    end
    n.status = (n.phase != ADCB_PH_AZ);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      q <= '0;
      q.cnt <= HALT;
    end
    else
      q <= n;
  end

  assign result = q.res;
  assign status = q.status;
  assign done = q.done;

  // refuse counts that the phase counters cannot hold
  if (CONV_COUNTS < 64 || CONV_COUNTS % 4 != 0 ||
      CONV_COUNTS >= (1 << CW))
  begin : g_bad_conv
    $error("adcb_phase_seq: CONV_COUNTS unusable");
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_latch_ends_status:
    assert property (q.done |-> (!q.status && $past(q.status)))
    else $error("status did not fall at latch");
  chk_halt_holds:
    assert property ((tick && q.phase == ADCB_PH_AZ && q.cnt == HALT
      && !run && !q.go && !start) |=> q.cnt == HALT)
    else $error("hold did not stop before integrate");
endmodule : adcb_phase_seq
`default_nettype wire

// file: pkg/adcb_consts.svh
// constants for the converter result byte output block
//
// Function
// - latched magnitude, 16 or 14 bits, sign, overrange
// - single conversions on request or continuous
// - sign valid even at zero count
// - status high integrate to latch, low auto-zero
// - sign output three-state, high for positive
// - data bits three-state, high means one
// - direct mode low enable with load drives bits 1-8
// - handshake mode low enable becomes flag output
// - 16-bit mid enable drives bits 9-16
// - 14-bit high enable drives 9-14, sign, overrange
// - 16-bit high enable drives sign, overrange only
// - mode pin selects direct or handshake transfer
// - load pin: master enable or load strobe
// - run/hold: continuous, or halt before integrate
`ifndef ADCB_CONSTS_SVH
`define ADCB_CONSTS_SVH

// apb register byte offsets
`define ADCB_OFF_CTRL    12'h000
`define ADCB_OFF_RESULT  12'h004
`define ADCB_OFF_IRQ_ST  12'h008
`define ADCB_OFF_IRQ_CLR 12'h00C
`define ADCB_OFF_IRQ_EN  12'h010
// field positions
`define ADCB_CTRL_START  0
`define ADCB_EVT_DONE    0
`define ADCB_EVT_HSDONE  1
`define ADCB_EVT_OVR     2
// reset values
`define ADCB_IRQ_EN_RST  3'h0
`define ADCB_SYNC_RST    8'hF0
// timing counts
`define ADCB_HALT_LEAD   7
`define ADCB_CONV_16     (1 << 17)
`define ADCB_CONV_14     (1 << 15)
`define ADCB_TICK_DIV    4
`define ADCB_CNT_W       20
// synchronised pin vector positions
`define ADCB_SY_MODE     0
`define ADCB_SY_RUN      1
`define ADCB_SY_PERMIT   2
`define ADCB_SY_COMP     3
`define ADCB_SY_BEN_LO   4
`define ADCB_SY_BEN_MID  5
`define ADCB_SY_BEN_HI   6
`define ADCB_SY_CEL      7

`endif

// file: pkg/adcb_pkg.sv
// types shared by the result byte output block
`default_nettype none
`include "adcb_consts.svh"
package adcb_pkg;
  typedef enum logic [1:0] {
    ADCB_PH_AZ  = 2'h0,
    ADCB_PH_INT = 2'h1,
    ADCB_PH_DE  = 2'h3
  } adcb_phase_t;

  typedef enum logic [1:0] {
    ADCB_HS_IDLE = 2'h0,
    ADCB_HS_WAIT = 2'h1,
    ADCB_HS_SEND = 2'h3,
    ADCB_HS_GAP  = 2'h2
  } adcb_hs_t;

  typedef struct packed {
    logic [15:0] mag;
    logic        sign;
    logic        ovr;
  } adcb_result_t;

  typedef struct packed {
    adcb_phase_t             phase;
    logic [`ADCB_CNT_W-1:0] cnt;
    logic [`ADCB_CNT_W-1:0] dcnt;
    logic                    go;
    logic                    status;
    logic                    done;
    adcb_result_t            res;
  } adcb_seq_st_t;

  typedef struct packed {
    logic [7:0]   s1;
    logic [7:0]   s2;
    logic         mode_prev;
    logic [7:0]   div;
    logic         tick;
    logic         start;
    adcb_result_t res;
    logic [15:0]  data;
    logic [15:0]  data_oe;
    logic         sign_oe;
    logic         ovr_oe;
    logic [2:0]   ben_out;
    logic [2:0]   ben_oe;
    logic         cel_out;
    logic         cel_oe;
    adcb_hs_t     hs;
    logic [1:0]   idx;
    logic [2:0]   irq_st;
    logic [2:0]   irq_en;
    logic         irq;
    logic [31:0]  prdata;
    logic         pready;
    logic         pslverr;
  } adcb_top_st_t;
endpackage : adcb_pkg
`default_nettype wire

// file: sim/adcb_host_model.sv
// host model that reads result bytes in handshake mode
`timescale 1ns/1ps
`default_nettype none
module adcb_host_model (
  input  wire logic        pclk,
  input  wire logic        stall,
  input  wire logic [15:0] data_out,
  input  wire logic [15:0] data_oe,
  input  wire logic        sign_out,
  input  wire logic        sign_oe,
  input  wire logic        overrange_out,
  input  wire logic        overrange_oe,
  input  wire logic [2:0]  ben_out,
  input  wire logic        cel_out,
  input  wire logic        cel_oe,
  output logic             transmit_permit
);
  logic [7:0] got [$];
  logic [7:0] cur;
  logic [7:0] hold_ff;
  logic       prev_cel_ff = 1'b1;

  // permit is a level; stall holds the sender in its wait state
  assign transmit_permit = cel_oe & ~stall;

  // undriven bits read as zero, so a missing enable shows up
  always_comb
  begin
    cur = 8'h00;
    if (!ben_out[0])
      cur = data_out[7:0] & data_oe[7:0];
    else if (!ben_out[1])
      cur = data_out[15:8] & data_oe[15:8];
    else if (!ben_out[2])
      cur = {6'h00, sign_out & sign_oe, overrange_out & overrange_oe};
  end

  // latch while the load strobe is low, keep it when the strobe ends
  always @(posedge pclk)
  begin
    if (cel_oe && !cel_out)
      hold_ff <= cur;
    if (cel_out && !prev_cel_ff)
      got.push_back(hold_ff);
    prev_cel_ff <= cel_out | ~cel_oe;
  end
endmodule : adcb_host_model
`default_nettype wire

// file: sim/tb_top.sv
// self-checking bench for the result byte output block
`timescale 1ns/1ps
`default_nettype none
`include "adcb_consts.svh"
module tb_top;
  localparam int CONV = 256;
  localparam int TDIV = 4;
  logic        pclk, presetn, psel, penable, pwrite, irq, err, s;
  logic        pready, pslverr, mode, run_hold_select, stall;
  logic        transmit_permit, comparator_in, conversion_status;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] data_out, data_oe;
  logic        sign_out, sign_oe, overrange_out, overrange_oe;
  logic [3:0]  drv, oe4, out4, pin, v;
  logic [17:0] e;
  int          fails = 0;
  int          n_compared = 0;
  int          cyc = 0;
  int          t0, hi_n;

  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // wire level of the shared enable pins
  assign pin = (oe4 & out4) | (~oe4 & drv);

  adcb_byte_out #(
    .RES_BITS(16), .CONV_COUNTS(CONV), .TICK_DIV(TDIV)
  ) dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .irq, .mode, .run_hold_select, .transmit_permit,
    .comparator_in, .conversion_status, .data_out, .data_oe, .sign_out,
    .sign_oe, .overrange_out, .overrange_oe,
    .low_byte_enable_in(pin[0]), .low_byte_enable_out(out4[0]),
    .low_byte_enable_oe(oe4[0]), .mid_byte_enable_in(pin[1]),
    .mid_byte_enable_out(out4[1]), .mid_byte_enable_oe(oe4[1]),
    .high_byte_enable_in(pin[2]), .high_byte_enable_out(out4[2]),
    .high_byte_enable_oe(oe4[2]), .chip_enable_load_in(pin[3]),
    .chip_enable_load_out(out4[3]), .chip_enable_load_oe(oe4[3])
  );

  adcb_host_model host (
    .pclk, .stall, .data_out, .data_oe, .sign_out, .sign_oe,
    .overrange_out, .overrange_oe, .ben_out(out4[2:0]),
    .cel_out(out4[3]), .cel_oe(oe4[3]), .transmit_permit
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check

  task automatic close_out;
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : close_out

  // one apb transfer; the answer is taken at the edge that shows pready
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wait_st(input logic lvl);
    int n;
    n = 0;
    do
    begin
      @(negedge pclk);
      n++;
    end
    while (conversion_status !== lvl && n < 3000);
    check(32'(conversion_status), 32'(lvl));
    @(posedge pclk);
  endtask : wait_st

  task automatic irq_is(input logic lvl);
    @(negedge pclk);
    check(32'(irq), 32'(lvl));
    @(posedge pclk);
  endtask : irq_is

  // overrange result: comparator never crosses during deintegrate
  function automatic logic [31:0] exp_res(input logic sg);
    return {14'h0, 1'b1, sg, 16'(CONV / 2 - 1)};
  endfunction : exp_res

  // groups driven for pin levels {load, high, mid, low}, 16-bit part
  function automatic logic [17:0] exp_oe(input logic [3:0] p);
    logic lo, mid, hi;
    lo = ~p[3] & ~p[0];
    mid = ~p[3] & ~p[1];
    hi = ~p[3] & ~p[2];
    return {hi, hi, {8{mid}}, {8{lo}}};
  endfunction : exp_oe

  // hang guard, well above the few thousand cycles the run needs
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      fails++;
      close_out();
    end
  end

  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    mode = 1'b0;
    run_hold_select = 1'b0;
    comparator_in = 1'b0;
    stall = 1'b1;
    drv = 4'hF;
    void'($urandom(32'h971A));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `ADCB_OFF_IRQ_EN, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, 12'h014, 32'h0);
    check({rd[30:0], err}, 32'h1);
    $display("end test 1");
    // single conversions of both polarities
    apb(1'b1, `ADCB_OFF_IRQ_EN, 32'h7);
    s = 1'($urandom);
    for (int k = 0; k < 2; k++)
    begin
      comparator_in <= s ^ k[0];
      apb(1'b1, `ADCB_OFF_CTRL, 32'h1);
      wait_st(1'b1);
      wait_st(1'b0);
      apb(1'b0, `ADCB_OFF_RESULT, 32'h0);
      check(rd, exp_res(s ^ k[0]));
    end
    s = ~s;
    apb(1'b0, `ADCB_OFF_IRQ_ST, 32'h0);
    check(rd, 32'h5);
    irq_is(1'b1);
    apb(1'b1, `ADCB_OFF_IRQ_EN, 32'h0);
    irq_is(1'b0);
    apb(1'b1, `ADCB_OFF_IRQ_CLR, 32'h7);
    apb(1'b0, `ADCB_OFF_IRQ_ST, 32'h0);
    check(rd, 32'h0);
    apb(1'b1, `ADCB_OFF_IRQ_EN, 32'h7);
    $display("end test 2");
    // direct mode: corners first, then random enable patterns
    for (int i = 0; i < 18; i++)
    begin
      v = (i < 2) ? 4'(i * 15) : 4'($urandom);
      drv <= v;
      repeat (3) @(posedge pclk);
      @(negedge pclk);
      e = exp_oe(v);
      check(32'({sign_oe, overrange_oe, data_oe}), 32'(e));
      check(32'({sign_out & sign_oe, overrange_out & overrange_oe,
                 data_out & data_oe}),
            32'({e[17] & s, e[16], e[15:0] & 16'h007F}));
      @(posedge pclk);
    end
    $display("end test 3");
    // handshake entered by a rising mode pin, receiver stalling first
    drv <= 4'hF;
    mode <= 1'b1;
    repeat (40) @(posedge pclk);
    @(negedge pclk);
    check(host.got.size(), 0);
    check(32'({oe4, out4}), 32'hFF);
    @(posedge pclk);
    stall <= 1'b0;
    for (int n = 0; n < 400 && host.got.size() < 3; n++)
      @(posedge pclk);
    check(host.got.size(), 3);
    if (host.got.size() == 3)
      check(32'({host.got[0], host.got[1], host.got[2]}),
            {8'h0, 8'h7F, 8'h00, 6'h0, s, 1'b1});
    // the done event follows the last strobe by a gap of one tick
    repeat (2 * TDIV) @(posedge pclk);
    apb(1'b0, `ADCB_OFF_IRQ_ST, 32'h0);
    check(rd & 32'h2, 32'h2);
    $display("end test 4");
    // continuous runs, then hold after the current conversion
    mode <= 1'b0;
    run_hold_select <= 1'b1;
    wait_st(1'b1);
    wait_st(1'b0);
    wait_st(1'b1);
    t0 = cyc;
    wait_st(1'b0);
    wait_st(1'b1);
    check(cyc - t0, CONV * TDIV);
    run_hold_select <= 1'b0;
    wait_st(1'b0);
    hi_n = 0;
    repeat (2 * CONV * TDIV)
    begin
      @(negedge pclk);
      hi_n += (conversion_status !== 1'b0);
    end
    check(hi_n, 0);
    $display("end test 5");
    close_out();
  end
endmodule : tb_top
`default_nettype wire
